// >>> hdl/conversion_clock_select_pkg.sv
// constants and types for the converter sequencer
package conversion_clock_select_pkg;
  localparam int unsigned RES_W     = 10;
  localparam int unsigned CHAN_W    = 4;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_RES_HI = 8'h08;
  localparam logic [7:0] ADDR_RES_LO = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // control register fields
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_GO    = 1;
  localparam int unsigned CTRL_CHS_L = 2;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  // timing register fields
  localparam int unsigned TIM_CS_L   = 0;
  localparam int unsigned TIM_ACQ_L  = 3;
  localparam int unsigned TIM_FMT    = 7;
  // status register fields
  localparam int unsigned ST_DONE    = 0;
  localparam int unsigned ST_IE      = 1;
  localparam int unsigned ST_PWR     = 2;
  localparam int unsigned ST_SAMP    = 3;
  // instruction cycle is four system clocks
  localparam int unsigned TCY_CLKS   = 4;
  localparam int unsigned DISCH_TADS = 2;
  localparam int unsigned CONV_TADS  = 11;
  localparam logic [1:0]  CS_FRC     = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_START = 3'h1,
    S_ACQ   = 3'h3,
    S_CONV  = 3'h2,
    S_DISCH = 3'h6
  } conversion_clock_select_state_t;

  // system clock divisor per conversion clock code
  function automatic logic [6:0] conversion_clock_select_div(input logic [2:0] sel);
    logic [6:0] d;
    d = 7'h02;
    unique case (sel)
      3'h0:    d = 7'h02;
      3'h4:    d = 7'h04;
      3'h1:    d = 7'h08;
      3'h5:    d = 7'h10;
      3'h2:    d = 7'h20;
      3'h6:    d = 7'h40;
      default: d = 7'h02;
    endcase
    return d;
  endfunction : conversion_clock_select_div

  // acquisition length in bit periods per code
  function automatic logic [4:0] conversion_clock_select_acq(input logic [2:0] sel);
    logic [4:0] a;
    a = 5'h00;
    unique case (sel)
      3'h0: a = 5'h00;
      3'h1: a = 5'h02;
      3'h2: a = 5'h04;
      3'h3: a = 5'h06;
      3'h4: a = 5'h08;
      3'h5: a = 5'h0C;
      3'h6: a = 5'h10;
      3'h7: a = 5'h14;
    endcase
    return a;
  endfunction : conversion_clock_select_acq
endpackage : conversion_clock_select_pkg

// >>> hdl/conversion_clock_select_tad_if.sv
// bit period request and tick between sequencer and divider
`timescale 1ns/1ps
interface conversion_clock_select_tad_if;
  logic [2:0] clk_sel;
  logic       run;
  logic       frc_tick;
  logic       tick;
  modport gen  (input clk_sel, run, frc_tick, output tick);
  modport user (output clk_sel, run, frc_tick, input tick);
endinterface : conversion_clock_select_tad_if

// >>> hdl/conversion_clock_select_tad_gen.sv
// bit period tick generator
`timescale 1ns/1ps
module conversion_clock_select_tad_gen (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  conversion_clock_select_tad_if.gen   tad
);
  logic [6:0] cnt;
  logic [6:0] div;

  assign div = conversion_clock_select_pkg::conversion_clock_select_div(tad.clk_sel);

  // divided system clock or the dedicated rc clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt      <= 7'h00;
      tad.tick <= 1'b0;
    end else if (!tad.run) begin
      cnt      <= 7'h00;
      tad.tick <= 1'b0;
    end else if (tad.clk_sel[1:0] == conversion_clock_select_pkg::CS_FRC) begin
      cnt      <= 7'h00;
      tad.tick <= tad.frc_tick;
    end else if (cnt == div - 7'h01) begin
      cnt      <= 7'h00;
      tad.tick <= 1'b1;
    end else begin
      cnt      <= cnt + 7'h01;
      tad.tick <= 1'b0;
    end
  end
endmodule : conversion_clock_select_tad_gen

// >>> hdl/conversion_clock_select_seq.sv
// converter sequencer top with apb registers
// Functional notes
// - clearing go mid-conversion aborts at once
// - abort writes partial result, fill last bit
// - reset clears registers, stops conversion
// - two bit periods wait before acquisition
// - after wait reconnect channel to capacitor
// - rc clock adds one instruction start delay
// - sleep plus interrupt enable wakes on done
// - sleep without interrupt powers down after
// - non-rc clock in sleep aborts, powers down
// - special trigger sets go in hardware
// - special trigger clears general timer
// - idle mode lets conversion complete
// - control register layout, reset zero
// - completion clears go, sets flag, loads
// - eleven bit periods, msb first
// - bit period from divider or rc
// - enable clear disables converter
`timescale 1ns/1ps
module conversion_clock_select_seq (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       sleep_i,
  input  wire logic                       frc_tick_i,
  input  wire logic                       trigger_i,
  input  wire logic                       comp_i,
  output logic      [conversion_clock_select_pkg::RES_W-1:0] trial_o,
  output logic      [conversion_clock_select_pkg::CHAN_W-1:0] channel_o,
  output logic                            sample_connect_o,
  output logic                            powered_o,
  output logic                            wake_o,
  output logic                            timer_clear_o
);
  localparam int unsigned RW = conversion_clock_select_pkg::RES_W;

  conversion_clock_select_tad_if tad ();
  conversion_clock_select_tad_gen u_tad (.clk_i(clk_i), .rst_n_i(rst_n_i), .tad(tad));

  conversion_clock_select_pkg::conversion_clock_select_state_t state;
  logic [3:0]    channel_select;
  logic          go;
  logic          enable;
  logic [2:0]    cs;
  logic [2:0]    acq;
  logic          fmt;
  logic          done_flag;
  logic          irq_en;
  logic          pwr_down;
  logic [4:0]    tad_cnt;
  logic [1:0]    tcy_cnt;
  logic [RW-1:0] sar;
  logic [RW-1:0] result;
  logic [RW-1:0] partial;
  logic [RW-1:0] fill_mask;
  logic          last_bit;
  logic          wr;
  logic          rd_phase;
  logic          wr_ctrl;
  logic          busy;
  logic          frc_sel;
  logic          sw_abort;
  logic          slp_abort;
  logic          start;
  logic          finish;
  logic [3:0]    pos;
  logic [7:0]    res_hi;
  logic [7:0]    res_lo;
  logic [7:0]    rd_byte;
  logic          mapped;

  assign tad.clk_sel  = cs;
  assign tad.frc_tick = frc_tick_i;
  assign tad.run      = (state == conversion_clock_select_pkg::S_ACQ) || (state == conversion_clock_select_pkg::S_CONV) ||
                        (state == conversion_clock_select_pkg::S_DISCH);

  assign frc_sel  = (cs[1:0] == conversion_clock_select_pkg::CS_FRC);
  assign busy     = (state == conversion_clock_select_pkg::S_START) || (state == conversion_clock_select_pkg::S_ACQ) ||
                    (state == conversion_clock_select_pkg::S_CONV);
  assign rd_phase = psel_i && penable_i && !pready_o;
  assign wr       = psel_i && penable_i && pready_o && pwrite_i;
  assign wr_ctrl  = wr && (paddr_i == conversion_clock_select_pkg::ADDR_CTRL);
  // software clearing go while running
  assign sw_abort  = wr_ctrl && !pwdata_i[conversion_clock_select_pkg::CTRL_GO] && busy;
  // sleep with a system derived clock; idle mode is not seen here and does not stop it
  assign slp_abort = sleep_i && !frc_sel && busy;
  assign start     = (state == conversion_clock_select_pkg::S_IDLE) && go && powered_o;
  assign finish    = (state == conversion_clock_select_pkg::S_CONV) && tad.tick &&
                     (tad_cnt == 5'(conversion_clock_select_pkg::CONV_TADS - 1));
  // next bit position to resolve during conversion
  assign pos       = 4'(RW) - tad_cnt[3:0];

  // unresolved bits copy the last resolved one
  genvar gi;
  generate
    for (gi = 0; gi < RW; gi++) begin : g_fill
      assign fill_mask[gi] = (tad_cnt <= 5'h01) || (4'(gi) <= pos);
      assign partial[gi]   = fill_mask[gi] ? (last_bit && tad_cnt > 5'h01) : sar[gi];
    end
  endgenerate

  // sequencer state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= conversion_clock_select_pkg::S_IDLE;
      tad_cnt <= 5'h00;
      tcy_cnt <= 2'h0;
    end else if (!powered_o && state == conversion_clock_select_pkg::S_IDLE) begin
      state   <= conversion_clock_select_pkg::S_IDLE;
      tad_cnt <= 5'h00;
      tcy_cnt <= 2'h0;
    end else if (sw_abort || slp_abort || (!enable && busy)) begin
      state   <= conversion_clock_select_pkg::S_DISCH;
      tad_cnt <= 5'h00;
    end else begin
      unique case (state)
        conversion_clock_select_pkg::S_IDLE: begin
          tcy_cnt <= 2'h0;
          tad_cnt <= 5'h00;
          if (start) begin
            state <= frc_sel ? conversion_clock_select_pkg::S_START : conversion_clock_select_pkg::S_ACQ;
          end
        end
        conversion_clock_select_pkg::S_START: begin
          tcy_cnt <= tcy_cnt + 2'h1;
          if (tcy_cnt == 2'(conversion_clock_select_pkg::TCY_CLKS - 1)) begin
            state <= conversion_clock_select_pkg::S_ACQ;
          end
        end
        conversion_clock_select_pkg::S_ACQ: begin
          if (conversion_clock_select_pkg::conversion_clock_select_acq(acq) == 5'h00) begin
            state <= conversion_clock_select_pkg::S_CONV;
          end else if (tad.tick) begin
            tad_cnt <= tad_cnt + 5'h01;
            if (tad_cnt == conversion_clock_select_pkg::conversion_clock_select_acq(acq) - 5'h01) begin
              state   <= conversion_clock_select_pkg::S_CONV;
              tad_cnt <= 5'h00;
            end
          end
        end
        conversion_clock_select_pkg::S_CONV: begin
          if (tad.tick) begin
            tad_cnt <= tad_cnt + 5'h01;
            if (finish) begin
              state   <= conversion_clock_select_pkg::S_DISCH;
              tad_cnt <= 5'h00;
            end
          end
        end
        conversion_clock_select_pkg::S_DISCH: begin
          if (tad.tick) begin
            tad_cnt <= tad_cnt + 5'h01;
            if (tad_cnt == 5'(conversion_clock_select_pkg::DISCH_TADS - 1)) begin
              state   <= conversion_clock_select_pkg::S_IDLE;
              tad_cnt <= 5'h00;
            end
          end
        end
        default: state <= conversion_clock_select_pkg::S_IDLE;
      endcase
    end
  end

  // successive approximation, msb first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sar      <= '0;
      last_bit <= 1'b0;
    end else if (state == conversion_clock_select_pkg::S_CONV && tad.tick && !sw_abort && !slp_abort) begin
      if (tad_cnt == 5'h00) begin
        sar <= {1'b1, {(RW-1){1'b0}}};
      end else begin
        sar[pos] <= comp_i;
        last_bit <= comp_i;
        if (pos != 4'h0) begin
          sar[pos - 4'h1] <= 1'b1;
        end
      end
    end else if (state == conversion_clock_select_pkg::S_IDLE) begin
      sar <= '0;
    end
  end

  // result load on completion or abort
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result <= '0;
    end else if (finish && !sw_abort && !slp_abort) begin
      result <= {sar[RW-1:1], comp_i};
    end else if ((sw_abort || slp_abort) && state == conversion_clock_select_pkg::S_CONV) begin
      result <= partial;
    end
  end

  // control register; trigger set wins over clears
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_select <= 4'h0;
      go     <= 1'b0;
      enable <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        channel_select <= pwdata_i[conversion_clock_select_pkg::CTRL_CHS_L +: 4];
        enable <= pwdata_i[conversion_clock_select_pkg::CTRL_EN];
      end
      if (trigger_i && enable) begin
        go <= 1'b1;
      end else if (finish || slp_abort || !enable || (!powered_o && !busy)) begin
        go <= 1'b0;
      end else if (wr_ctrl) begin
        go <= pwdata_i[conversion_clock_select_pkg::CTRL_GO] && pwdata_i[conversion_clock_select_pkg::CTRL_EN];
      end
    end
  end

  // timing, flag and enable registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs        <= 3'h0;
      acq       <= 3'h0;
      fmt       <= 1'b0;
      irq_en    <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      if (wr && paddr_i == conversion_clock_select_pkg::ADDR_TIMING) begin
        cs  <= pwdata_i[conversion_clock_select_pkg::TIM_CS_L +: 3];
        acq <= pwdata_i[conversion_clock_select_pkg::TIM_ACQ_L +: 3];
        fmt <= pwdata_i[conversion_clock_select_pkg::TIM_FMT];
      end
      if (wr && paddr_i == conversion_clock_select_pkg::ADDR_STATUS) begin
        irq_en <= pwdata_i[conversion_clock_select_pkg::ST_IE];
      end
      if (finish) begin
        done_flag <= 1'b1;
      end else if (wr && paddr_i == conversion_clock_select_pkg::ADDR_STATUS && pwdata_i[conversion_clock_select_pkg::ST_DONE]) begin
        done_flag <= 1'b0;
      end
    end
  end

  // sleep power down, released when sleep ends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_down <= 1'b0;
    end else if (!sleep_i) begin
      pwr_down <= 1'b0;
    end else if (slp_abort || (finish && !irq_en)) begin
      pwr_down <= 1'b1;
    end
  end

  // pin side outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      powered_o        <= 1'b0;
      sample_connect_o <= 1'b0;
      channel_o        <= 4'h0;
      trial_o          <= '0;
      wake_o           <= 1'b0;
      timer_clear_o    <= 1'b0;
    end else begin
      powered_o        <= enable && !pwr_down && !(sleep_i && finish && !irq_en);
      sample_connect_o <= enable && !pwr_down && (state == conversion_clock_select_pkg::S_IDLE ||
                          state == conversion_clock_select_pkg::S_START || state == conversion_clock_select_pkg::S_ACQ);
      channel_o        <= channel_select;
      trial_o          <= sar;
      wake_o           <= finish && sleep_i && irq_en;
      timer_clear_o    <= trigger_i;
    end
  end

  assign res_hi = fmt ? {6'h00, result[RW-1:8]} : result[RW-1:2];
  assign res_lo = fmt ? result[7:0] : {result[1:0], 6'h00};
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr_i)
      conversion_clock_select_pkg::ADDR_CTRL:   rd_byte = {2'h0, channel_select, go, enable};
      conversion_clock_select_pkg::ADDR_TIMING: rd_byte = {fmt, 1'b0, acq, cs};
      conversion_clock_select_pkg::ADDR_RES_HI: rd_byte = res_hi;
      conversion_clock_select_pkg::ADDR_RES_LO: rd_byte = res_lo;
      conversion_clock_select_pkg::ADDR_STATUS: rd_byte = {4'h0, sample_connect_o, powered_o, irq_en, done_flag};
      default:               mapped  = 1'b0;
    endcase
  end

  // apb slave, one wait state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= rd_phase;
      pslverr_o <= rd_phase && !mapped;
      prdata_o  <= (rd_phase && !pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  sequence s_disch_enter;
    state == conversion_clock_select_pkg::S_DISCH && $past(state) != conversion_clock_select_pkg::S_DISCH;
  endsequence
  sequence s_frc_start;
    state == conversion_clock_select_pkg::S_START && $past(state) == conversion_clock_select_pkg::S_IDLE;
  endsequence

  a_abort_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sw_abort && enable |=> state == conversion_clock_select_pkg::S_DISCH)
    else $error("abort did not stop conversion");
  a_disch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_disch_enter |-> (state == conversion_clock_select_pkg::S_DISCH)[*2])
    else $error("discharge wait too short");
  a_frc_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_frc_start |-> (state == conversion_clock_select_pkg::S_START)[*4] ##1 state != conversion_clock_select_pkg::S_START)
    else $error("rc start delay wrong");
  a_done_go_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    finish && !sw_abort && !slp_abort |=> !go && done_flag)
    else $error("completion did not clear go or set flag");
  a_trig_go: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    trigger_i && enable |=> go)
    else $error("trigger did not set go");
  a_trig_timer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    trigger_i |=> timer_clear_o)
    else $error("trigger did not clear timer");
  a_sleep_abort: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    slp_abort |=> state == conversion_clock_select_pkg::S_DISCH && !go ##1 !powered_o && enable)
    else $error("sleep abort missing");
  a_ctrl_upper: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_phase && !pwrite_i && paddr_i == conversion_clock_select_pkg::ADDR_CTRL |=> prdata_o[7:6] == 2'h0)
    else $error("unimplemented control bits set");
  a_disable_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !enable |=> !powered_o)
    else $error("disabled converter still powered");
  a_wake_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    finish && sleep_i && irq_en |=> wake_o)
    else $error("no wake on completion");
endmodule : conversion_clock_select_seq

// >>> dv/conversion_clock_select_analog_model.sv
// analog channel and holding capacitor model
`timescale 1ns/1ps
module conversion_clock_select_analog_model (
  input  wire logic       clk_i,
  input  wire logic [9:0] level_i,
  input  wire logic [9:0] trial_i,
  input  wire logic       connect_i,
  input  wire logic       powered_i,
  output logic            comp_o
);
  logic [9:0] held = 10'h000;
  logic       tog  = 1'b0;
  // capacitor tracks the channel only while connected
  always @(posedge clk_i) begin
    if (connect_i) held <= level_i;
    tog <= ~tog;
  end
  // unpowered comparator gives no stable answer
  assign comp_o = powered_i ? (held >= trial_i) : tog;
endmodule : conversion_clock_select_analog_model

// >>> dv/conversion_clock_select_seq_test.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module conversion_clock_select_seq_test;
  logic        clk_i    = 1'b0;
  logic        rst_n_i  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        sleep    = 1'b0;
  logic        frc_tick = 1'b0;
  logic        trigger  = 1'b0;
  logic [2:0]  fcnt     = 3'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, comp, connect, powered, wake, tclr, err;
  logic [9:0]  trial;
  logic [3:0]  channel;
  logic [9:0]  lvl [16];
  logic [2:0]  cs_tab [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int          num_errors = 0;
  int          n_compared = 0;
  int          lat, k, seed;
  int          exp_q [$];

  conversion_clock_select_seq u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sleep_i(sleep), .frc_tick_i(frc_tick),
    .trigger_i(trigger), .comp_i(comp), .trial_o(trial), .channel_o(channel),
    .sample_connect_o(connect), .powered_o(powered), .wake_o(wake), .timer_clear_o(tclr)
  );
  conversion_clock_select_analog_model u_ana (
    .clk_i(clk_i), .level_i(lvl[channel]), .trial_i(trial), .connect_i(connect),
    .powered_i(powered), .comp_o(comp)
  );

  always #2 clk_i = ~clk_i;
  // rc bit period pulse every six clocks
  always @(posedge clk_i) begin
    fcnt     <= (fcnt == 3'h5) ? 3'h0 : fcnt + 3'h1;
    frc_tick <= (fcnt == 3'h0);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_pin(ref logic s, input logic v, input int lim);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= lim) num_errors++;
  endtask : wait_pin

  task automatic conv(input logic [3:0] ch, input logic [7:0] tim, input int v);
    lvl[ch] = v[9:0];
    apb(1'b1, conversion_clock_select_pkg::ADDR_TIMING, {24'h0, tim});
    apb(1'b1, conversion_clock_select_pkg::ADDR_CTRL, {26'h0, ch, 2'b01});
    repeat (40) @(posedge clk_i);
    apb(1'b1, conversion_clock_select_pkg::ADDR_CTRL, {26'h0, ch, 2'b11});
    exp_q.push_back(v);
    wait_pin(connect, 1'b0, 5000);
    lat = k;
  endtask : conv

  task automatic wait_go();
    int n;
    n = 0;
    do begin
      apb(1'b0, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 1000);
    if (n >= 1000) num_errors++;
  endtask : wait_go

  task automatic check_res(input logic right);
    int v;
    v = exp_q.pop_front();
    apb(1'b0, conversion_clock_select_pkg::ADDR_RES_HI, 32'h0);
    check(rd, right ? v >> 8 : v >> 2, "result high");
    apb(1'b0, conversion_clock_select_pkg::ADDR_RES_LO, 32'h0);
    check(rd, right ? v & 'hFF : (v & 3) << 6, "result low");
  endtask : check_res

  task automatic complete_run();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    seed = $urandom(62913);
    foreach (lvl[i]) lvl[i] = 10'h000;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0, "control reset");
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, conversion_clock_select_pkg::ADDR_CTRL, 32'hFFFFFFFD);
    apb(1'b0, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h3D, "control layout");
    for (int i = 0; i < 7; i++) begin
      conv(4'($urandom_range(15)), {i[0], 1'b0, 3'($urandom_range(7)), cs_tab[i]},
           $urandom_range(1023));
      if (i == 6) check(lat >= conversion_clock_select_pkg::TCY_CLKS, 1, "rc start delay");
      wait_go();
      check(rd[1:0], 2'b01, "go cleared");
      check_res(i[0]);
      apb(1'b0, conversion_clock_select_pkg::ADDR_STATUS, 32'h0);
      check(rd[2:0], 3'b101, "done set");
      apb(1'b1, conversion_clock_select_pkg::ADDR_STATUS, 32'h1);
      apb(1'b0, conversion_clock_select_pkg::ADDR_STATUS, 32'h0);
      check(rd[0], 1'b0, "done cleared");
    end
    conv(4'h5, 8'h06, 700);
    wait_pin(connect, 1'b1, 2000);
    check(k > 800 && k < 864, 1, "wait before reconnect");
    wait_go();
    check_res(1'b0);
    conv(4'h7, 8'h06, 1023);
    repeat (300) @(posedge clk_i);
    apb(1'b1, conversion_clock_select_pkg::ADDR_CTRL, {26'h0, 4'h7, 2'b01});
    apb(1'b0, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h1D, "abort clears go");
    check_res(1'b0);
    lvl[9] = 10'h155;
    apb(1'b1, conversion_clock_select_pkg::ADDR_TIMING, 32'h0);
    apb(1'b1, conversion_clock_select_pkg::ADDR_CTRL, {26'h0, 4'h9, 2'b01});
    repeat (200) @(posedge clk_i);
    trigger <= 1'b1;
    @(posedge clk_i);
    trigger <= 1'b0;
    @(negedge clk_i);
    check(tclr, 1'b1, "timer clear");
    exp_q.push_back(32'h155);
    wait_go();
    check_res(1'b0);
    conv(4'h3, 8'h06, 512);
    repeat (100) @(posedge clk_i);
    sleep <= 1'b1;
    repeat (4) @(negedge clk_i);
    check(powered, 1'b0, "sleep powers down");
    apb(1'b0, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0D, "sleep abort keeps enable");
    sleep <= 1'b0;
    exp_q.delete();
    apb(1'b1, conversion_clock_select_pkg::ADDR_STATUS, 32'h3);
    conv(4'h4, 8'h03, 300);
    @(posedge clk_i);
    sleep <= 1'b1;
    wait_pin(wake, 1'b1, 3000);
    check(wake, 1'b1, "wake on done");
    @(posedge clk_i);
    sleep <= 1'b0;
    check_res(1'b0);
    apb(1'b1, conversion_clock_select_pkg::ADDR_STATUS, 32'h1);
    conv(4'h6, 8'h03, 99);
    @(posedge clk_i);
    sleep <= 1'b1;
    wait_pin(powered, 1'b0, 3000);
    check(powered, 1'b0, "powered down after done");
    apb(1'b0, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h19, "enable kept");
    check_res(1'b0);
    sleep <= 1'b0;
    apb(1'b1, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(negedge clk_i);
    check(powered, 1'b0, "disabled");
    conv(4'h2, 8'h06, 640);
    repeat (100) @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({connect, powered}, 2'b00, "reset stops");
    rst_n_i <= 1'b1;
    exp_q.delete();
    apb(1'b0, conversion_clock_select_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0, "control after reset");
    apb(1'b0, conversion_clock_select_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h0, "status after reset");
    complete_run();
  end
endmodule : conversion_clock_select_seq_test
